/* File: include/smfw_pkg.sv */
//Contract
//- Remote mode requests accepted only with selector at remote position.
//- From remote stop: run or debug allowed, pause refused.
//- From remote run: pause or stop allowed, debug refused.
//- From remote pause: run or stop allowed, debug refused.
//- From debug: only remote stop allowed.
//- Diagnosis fault at power-up or runtime halts program execution.
//- Watchdog interval is a software-set value, not a constant.
//- Watchdog restarts when end-of-scan processing finishes.
//- Watchdog times out if scan end not reached within interval.
//- On timeout: outputs off, fault indicator blinks, running indicator off.
//- Kick instruction restarts watchdog count mid-scan.
//- The first error writes its code into the system error flag; later errors leave that code in place until reset.
//- All-outputs-off command beats forced output values.
//- Every input and output bit has own force enable and value.
//- Per-bit forcing acts only while global force enable is set.
//- One global enable bit, two blocks of 64 sixteen-bit words, readable.
//- Input refresh replaces force-enabled bits before writing input image.
//- Output refresh forces physical outputs only, output image untouched.
//- Force settings survive power cycle, mode change and reset.
//- Entering stop mode does not clear force settings.
//- Direct refresh moves inputs or outputs at once, mid-scan.
`default_nettype none
package smfw_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int WDT_TICK_US   = 1000;
  localparam int WDT_TICK_CYC  = WDT_TICK_US * 1000 / CLK_PERIOD_NS;
  localparam int BLINK_MS      = 500;
  localparam int BLINK_CYC     = BLINK_MS * 1000000 / CLK_PERIOD_NS;

  localparam logic [11:0] OFS_CTRL     = 12'h000;
  localparam logic [11:0] OFS_MODE_REQ = 12'h004;
  localparam logic [11:0] OFS_STATUS   = 12'h008;
  localparam logic [11:0] OFS_WDT_LIM  = 12'h00C;
  localparam logic [11:0] OFS_SYS_ERR  = 12'h010;
  localparam logic [3:0]  PAGE_FEN     = 4'h1;
  localparam logic [3:0]  PAGE_FVAL    = 4'h2;

  localparam int CTRL_GFE_BIT   = 0;
  localparam int CTRL_CLR_EN    = 1;
  localparam int CTRL_CLR_VAL   = 2;
  localparam int ST_HALT_BIT    = 8;
  localparam int ST_ACC_BIT     = 9;
  localparam int ST_REJ_BIT     = 10;
  localparam int ST_WDT_BIT     = 11;

  localparam int FORCE_WORDS = 64;
  localparam int IO_WORDS    = 4;
  localparam int IN_WORD0    = 0;
  localparam int OUT_WORD0   = 4;
  localparam int IO_BITS     = 64;

  localparam logic [15:0] WDT_LIM_RST = 16'h00C8;
  localparam logic [15:0] ERR_NONE    = 16'h0000;
  localparam logic [15:0] ERR_WDT     = 16'h0011;
  localparam logic [15:0] ERR_DIAG    = 16'h0012;

  localparam logic [1:0] SEL_RUN    = 2'h0;
  localparam logic [1:0] SEL_STOP   = 2'h1;
  localparam logic [1:0] SEL_PAUREM = 2'h2;

  localparam logic [1:0] REQ_STOP  = 2'h0;
  localparam logic [1:0] REQ_RUN   = 2'h1;
  localparam logic [1:0] REQ_PAUSE = 2'h2;
  localparam logic [1:0] REQ_DEBUG = 2'h3;

  typedef enum logic [6:0] {
    M_LSTOP  = 7'h01,
    M_LRUN   = 7'h02,
    M_LPAUSE = 7'h04,
    M_RSTOP  = 7'h08,
    M_RRUN   = 7'h10,
    M_RPAUSE = 7'h20,
    M_DEBUG  = 7'h40
  } smfw_mode_t;
endpackage
`default_nettype wire

/* File: src/smfw_top.sv */
// Decided for this implementation: the address map and the AHB-Lite interface to the registers.
`default_nettype none
module smfw_top #(
  parameter int WDT_TICK_CYC = smfw_pkg::WDT_TICK_CYC,
  parameter int BLINK_CYC    = smfw_pkg::BLINK_CYC
) (
  input  wire logic        core_clk,        // 100 MHz scan clock
  input  wire logic        nrst,            // Sync reset, active low
  input  wire logic        hsel,            // AHB slave select
  input  wire logic [31:0] haddr,           // AHB address
  input  wire logic [1:0]  htrans,          // AHB transfer type
  input  wire logic        hwrite,          // AHB write
  input  wire logic [2:0]  hsize,           // AHB size, word only
  input  wire logic [31:0] hwdata,          // AHB write data
  input  wire logic        hready,          // AHB bus ready
  output logic      [31:0] hrdata,          // AHB read data
  output logic             hreadyout,       // AHB slave ready
  output logic             hresp,           // AHB response, OKAY
  input  wire logic [1:0]  selector_pos,    // Mode switch pins
  input  wire logic        diag_fault,      // Self-check fault pin
  input  wire logic        backup_invalid,  // Retention memory lost
  input  wire logic        scan_start,      // End-of-scan done pulse
  input  wire logic        watchdog_kick_instruction,   // Kick pulse
  input  wire logic        direct_refresh_instruction,  // Pulse
  input  wire logic        direct_refresh_dir,          // 1 out, 0 in
  input  wire logic        all_outputs_off_command,     // Level
  input  wire logic        input_refresh,   // Input refresh pulse
  input  wire logic        output_refresh,  // Output refresh pulse
  input  wire logic [63:0] field_in,        // Physical input pins
  input  wire logic [63:0] out_image,       // Output image from core
  output logic      [63:0] in_image,        // Input image to core
  output logic      [63:0] field_out,       // Physical output pins
  output logic             program_enable,  // Program may execute
  output logic      [6:0]  op_mode,         // One-hot operating mode
  output logic             fault_indicator, // Blinks while halted
  output logic             running_indicator // On while running
);
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [63:0] force_mix(input logic [63:0] raw,
                                            input logic [63:0] en,
                                            input logic [63:0] val,
                                            input logic        gfe);
    force_mix = gfe ? ((raw & ~en) | (val & en)) : raw;
  endfunction

  function automatic logic req_legal(input smfw_pkg::smfw_mode_t m,
                                     input logic [1:0] t);
    req_legal = 1'b0;
    case (m)
      smfw_pkg::M_RSTOP:  req_legal = (t == smfw_pkg::REQ_RUN) ||
                                      (t == smfw_pkg::REQ_DEBUG);
      smfw_pkg::M_RRUN:   req_legal = (t == smfw_pkg::REQ_PAUSE) ||
                                      (t == smfw_pkg::REQ_STOP);
      smfw_pkg::M_RPAUSE: req_legal = (t == smfw_pkg::REQ_RUN) ||
                                      (t == smfw_pkg::REQ_STOP);
      smfw_pkg::M_DEBUG:  req_legal = (t == smfw_pkg::REQ_STOP);
      default:            req_legal = 1'b0;
    endcase
  endfunction

  function automatic smfw_pkg::smfw_mode_t req_mode(input logic [1:0] t);
    case (t)
      smfw_pkg::REQ_RUN:   req_mode = smfw_pkg::M_RRUN;
      smfw_pkg::REQ_PAUSE: req_mode = smfw_pkg::M_RPAUSE;
      smfw_pkg::REQ_DEBUG: req_mode = smfw_pkg::M_DEBUG;
      default:             req_mode = smfw_pkg::M_RSTOP;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [1:0] sel_s1_r, sel_s2_r, sel_prev_r;
  logic       diag_s1_r, diag_s2_r, binv_s1_r, binv_s2_r;
  logic [63:0] fin_s1_r, fin_s2_r;

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      sel_s1_r  <= smfw_pkg::SEL_STOP;
      sel_s2_r  <= smfw_pkg::SEL_STOP;
      diag_s1_r <= 1'b0;
      diag_s2_r <= 1'b0;
      binv_s1_r <= 1'b0;
      binv_s2_r <= 1'b0;
      fin_s1_r  <= 64'h0;
      fin_s2_r  <= 64'h0;
    end else begin
      sel_s1_r  <= selector_pos;
      sel_s2_r  <= sel_s1_r;
      diag_s1_r <= diag_fault;
      diag_s2_r <= diag_s1_r;
      binv_s1_r <= backup_invalid;
      binv_s2_r <= binv_s1_r;
      fin_s1_r  <= field_in;
      fin_s2_r  <= fin_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave, zero wait states; read data latched in address phase
  logic        ap_wr_r;
  logic [11:0] ap_addr_r;
  logic [31:0] hrdata_r;
  wire         ap_valid = hsel & htrans[1] & hready;
  wire  [11:0] ra       = haddr[11:0];
  wire         wr_ctrl  = ap_wr_r && (ap_addr_r == smfw_pkg::OFS_CTRL);
  wire         wr_req   = ap_wr_r && (ap_addr_r == smfw_pkg::OFS_MODE_REQ);
  wire         wr_stat  = ap_wr_r && (ap_addr_r == smfw_pkg::OFS_STATUS);
  wire         wr_lim   = ap_wr_r && (ap_addr_r == smfw_pkg::OFS_WDT_LIM);
  wire         wr_fen   = ap_wr_r && (ap_addr_r[11:8] == smfw_pkg::PAGE_FEN);
  wire         wr_fval  = ap_wr_r &&
                          (ap_addr_r[11:8] == smfw_pkg::PAGE_FVAL);

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      ap_wr_r   <= 1'b0;
      ap_addr_r <= 12'h000;
    end else begin
      ap_wr_r   <= ap_valid & hwrite;
      ap_addr_r <= ra;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;

  ////////////////////////////////////////////////////////////////////////
  // Force storage: battery-backed, so nrst leaves it alone
  logic [15:0] fen_mem [smfw_pkg::FORCE_WORDS];
  logic [15:0] fval_mem [smfw_pkg::FORCE_WORDS];
  logic        gfe_r;

  always_ff @(posedge core_clk) begin
    if (binv_s2_r) begin
      gfe_r <= 1'b0;
    end else if (wr_ctrl) begin
      gfe_r <= hwdata[smfw_pkg::CTRL_GFE_BIT];
    end
  end

  always_ff @(posedge core_clk) begin
    for (int i = 0; i < smfw_pkg::FORCE_WORDS; i++) begin
      if (binv_s2_r || (wr_ctrl && hwdata[smfw_pkg::CTRL_CLR_EN])) begin
        fen_mem[i] <= 16'h0000;
      end else if (wr_fen && (ap_addr_r[7:2] == 6'(i))) begin
        fen_mem[i] <= hwdata[15:0];
      end
      if (binv_s2_r || (wr_ctrl && hwdata[smfw_pkg::CTRL_CLR_VAL])) begin
        fval_mem[i] <= 16'h0000;
      end else if (wr_fval && (ap_addr_r[7:2] == 6'(i))) begin
        fval_mem[i] <= hwdata[15:0];
      end
    end
  end

  logic [63:0] in_fen, in_fval, out_fen, out_fval;
  for (genvar g = 0; g < smfw_pkg::IO_WORDS; g++) begin : g_pack
    assign in_fen[16*g +: 16]   = fen_mem[smfw_pkg::IN_WORD0 + g];
    assign in_fval[16*g +: 16]  = fval_mem[smfw_pkg::IN_WORD0 + g];
    assign out_fen[16*g +: 16]  = fen_mem[smfw_pkg::OUT_WORD0 + g];
    assign out_fval[16*g +: 16] = fval_mem[smfw_pkg::OUT_WORD0 + g];
  end

  ////////////////////////////////////////////////////////////////////////
  // Operating mode
  smfw_pkg::smfw_mode_t mode_r, mode_nxt;
  logic        halted_r, wdt_err_r, req_acc_r, req_rej_r;
  logic [15:0] wdt_lim_r, sys_err_r;
  wire         sel_chg   = (sel_s2_r != sel_prev_r);
  wire         remote_ok = (sel_s2_r == smfw_pkg::SEL_PAUREM) &&
                           (mode_r inside {smfw_pkg::M_RSTOP,
                            smfw_pkg::M_RRUN, smfw_pkg::M_RPAUSE,
                            smfw_pkg::M_DEBUG});
  wire         req_take  = wr_req && remote_ok && !sel_chg &&
                           req_legal(mode_r, hwdata[1:0]);

  always_comb begin
    mode_nxt = mode_r;
    if (sel_chg) begin
      case (sel_s2_r)
        smfw_pkg::SEL_RUN:  mode_nxt = smfw_pkg::M_LRUN;
        smfw_pkg::SEL_STOP: mode_nxt = smfw_pkg::M_LSTOP;
        default: mode_nxt = (sel_prev_r == smfw_pkg::SEL_STOP) ?
                            smfw_pkg::M_RSTOP : smfw_pkg::M_LPAUSE;
      endcase
    end else if (req_take) begin
      mode_nxt = req_mode(hwdata[1:0]);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      mode_r     <= smfw_pkg::M_LSTOP;
      sel_prev_r <= smfw_pkg::SEL_STOP;
    end else begin
      mode_r     <= mode_nxt;
      sel_prev_r <= sel_s2_r;
    end
  end

  // A request racing a status clear keeps its flag: set beats clear
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      req_acc_r <= 1'b0;
      req_rej_r <= 1'b0;
    end else begin
      req_acc_r <= (wr_req && req_take) ||
                   (req_acc_r && !(wr_stat && hwdata[smfw_pkg::ST_ACC_BIT]));
      req_rej_r <= (wr_req && !req_take) ||
                   (req_rej_r && !(wr_stat && hwdata[smfw_pkg::ST_REJ_BIT]));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Watchdog: millisecond prescaler plus software-set tick limit
  logic [31:0] pre_r;
  logic [15:0] wdt_cnt_r;
  wire running   = (mode_r inside {smfw_pkg::M_LRUN, smfw_pkg::M_RRUN,
                                   smfw_pkg::M_DEBUG}) && !halted_r;
  wire wdt_rst   = scan_start | watchdog_kick_instruction | !running;
  wire tick      = (pre_r == 32'(WDT_TICK_CYC - 1));
  wire wdt_trip  = running && !wdt_rst && tick &&
                   (wdt_cnt_r + 16'h0001 >= wdt_lim_r);
  wire diag_trip = diag_s2_r && !halted_r;

  always_ff @(posedge core_clk) begin
    if (!nrst || wdt_rst) begin
      pre_r     <= 32'h0;
      wdt_cnt_r <= 16'h0000;
    end else if (tick) begin
      pre_r     <= 32'h0;
      wdt_cnt_r <= wdt_cnt_r + 16'h0001;
    end else begin
      pre_r     <= pre_r + 32'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      wdt_lim_r <= smfw_pkg::WDT_LIM_RST;
    end else if (wr_lim && (hwdata[15:0] != 16'h0000)) begin
      wdt_lim_r <= hwdata[15:0];
    end
  end

  // Fault latches until reset; first cause wins the error code
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      halted_r  <= 1'b0;
      wdt_err_r <= 1'b0;
      sys_err_r <= smfw_pkg::ERR_NONE;
    end else if (!halted_r && (wdt_trip || diag_trip)) begin
      halted_r  <= 1'b1;
      wdt_err_r <= wdt_trip;
      sys_err_r <= wdt_trip ? smfw_pkg::ERR_WDT : smfw_pkg::ERR_DIAG;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Indicators
  logic [31:0] blink_cnt_r;
  logic        blink_r;
  always_ff @(posedge core_clk) begin
    if (!nrst || !halted_r) begin
      blink_cnt_r <= 32'h0;
      blink_r     <= 1'b1;
    end else if (blink_cnt_r == 32'(BLINK_CYC - 1)) begin
      blink_cnt_r <= 32'h0;
      blink_r     <= ~blink_r;
    end else begin
      blink_cnt_r <= blink_cnt_r + 32'h1;
    end
  end

  assign fault_indicator   = halted_r & blink_r;
  assign running_indicator = running;
  assign program_enable    = running;
  assign op_mode           = mode_r;

  ////////////////////////////////////////////////////////////////////////
  // Image refresh with forcing
  logic [63:0] in_image_r, field_out_r;
  wire  [63:0] in_forced  = force_mix(fin_s2_r, in_fen, in_fval, gfe_r);
  wire  [63:0] out_forced = force_mix(out_image, out_fen, out_fval, gfe_r);
  // A trip cuts the outputs on the same edge that latches the halt
  wire         outs_off   = all_outputs_off_command | halted_r |
                            wdt_trip | diag_trip;
  wire         do_in      = input_refresh |
                            (direct_refresh_instruction & ~direct_refresh_dir);
  wire         do_out     = output_refresh |
                            (direct_refresh_instruction & direct_refresh_dir);

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      in_image_r <= 64'h0;
    end else if (do_in) begin
      in_image_r <= in_forced;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst || outs_off) begin
      field_out_r <= 64'h0;
    end else if (do_out) begin
      field_out_r <= out_forced;
    end
  end

  assign in_image  = in_image_r;
  assign field_out = field_out_r;

  ////////////////////////////////////////////////////////////////////////
  // Register read mux
  wire [31:0] stat_word = {20'h0, wdt_err_r, req_rej_r, req_acc_r,
                           halted_r, 1'b0, mode_r};
  wire [31:0] rd_word =
    (ra == smfw_pkg::OFS_CTRL)        ? {31'h0, gfe_r} :
    (ra == smfw_pkg::OFS_STATUS)      ? stat_word :
    (ra == smfw_pkg::OFS_WDT_LIM)     ? {16'h0, wdt_lim_r} :
    (ra == smfw_pkg::OFS_SYS_ERR)     ? {16'h0, sys_err_r} :
    (ra[11:8] == smfw_pkg::PAGE_FEN)  ? {16'h0, fen_mem[ra[7:2]]} :
    (ra[11:8] == smfw_pkg::PAGE_FVAL) ? {16'h0, fval_mem[ra[7:2]]} :
                                        32'h0;

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      hrdata_r <= 32'h0;
    end else if (ap_valid && !hwrite) begin
      hrdata_r <= rd_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  sequence req_at(smfw_pkg::smfw_mode_t m, logic [1:0] t);
    wr_req && !sel_chg && mode_r == m && hwdata[1:0] == t;
  endsequence

  remote_gate_a: assert property (
    wr_req && !remote_ok && !sel_chg |=> $stable(mode_r) && req_rej_r)
    else $error("remote request taken outside remote position");
  stop_pause_a: assert property (
    req_at(smfw_pkg::M_RSTOP, smfw_pkg::REQ_PAUSE) |=>
      mode_r == smfw_pkg::M_RSTOP)
    else $error("remote stop moved to pause");
  run_debug_a: assert property (
    req_at(smfw_pkg::M_RRUN, smfw_pkg::REQ_DEBUG) |=>
      mode_r == smfw_pkg::M_RRUN)
    else $error("remote run moved to debug");
  pause_run_a: assert property (
    req_at(smfw_pkg::M_RPAUSE, smfw_pkg::REQ_RUN) ##0
      sel_s2_r == smfw_pkg::SEL_PAUREM |=> mode_r == smfw_pkg::M_RRUN)
    else $error("remote pause did not resume");
  debug_exit_a: assert property (
    req_at(smfw_pkg::M_DEBUG, smfw_pkg::REQ_RUN) |=>
      mode_r == smfw_pkg::M_DEBUG)
    else $error("debug left for run");
  diag_halt_a: assert property (
    diag_s2_r |=> halted_r && !program_enable)
    else $error("diagnosis fault did not halt");
  wdt_timeout_a: assert property (
    wdt_trip |=> halted_r && field_out == 64'h0 && !running_indicator
      && sys_err_r == smfw_pkg::ERR_WDT)
    else $error("watchdog timeout effects missing");
  kick_clear_a: assert property (
    watchdog_kick_instruction |=> wdt_cnt_r == 16'h0000 && pre_r == 32'h0)
    else $error("kick did not restart watchdog");
  all_outputs_off_command_wins_a: assert property (
    all_outputs_off_command |=> field_out == 64'h0)
    else $error("forced output beat all-off");
  in_force_a: assert property (
    do_in && gfe_r |=>
      ((in_image ^ $past(in_fval)) & $past(in_fen)) == 64'h0)
    else $error("forced input bit not applied");
  out_force_a: assert property (
    do_out && !outs_off && !gfe_r |=> field_out == $past(out_image))
    else $error("output changed while forcing off");
endmodule
`default_nettype wire

/* File: dv/smfw_field_model.sv */
`default_nettype none
module smfw_field_model (
  input  wire logic        core_clk,  // Scan clock
  input  wire logic [63:0] pattern,   // Level the field applies
  input  wire logic [63:0] field_out, // Pins from the block
  output logic      [63:0] field_in,  // Pins to the block
  output logic      [63:0] latched    // Outputs as the field saw them
);
  timeunit 1ns;
  timeprecision 1ns;
  // Input modules hold their pins steady; the bench changes them well
  // ahead of a refresh so the two sync stages have settled
  assign field_in = pattern;
  always_ff @(posedge core_clk) begin
    latched <= field_out;
  end
endmodule
`default_nettype wire

/* File: dv/testbench.sv */
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rdv;
  logic        hreadyout, hresp, program_enable, fault_ind, run_ind;
  logic [1:0]  sel = smfw_pkg::SEL_STOP;
  logic        diag = 1'b0, bkinv = 1'b1, scan = 1'b0, kick = 1'b0;
  logic        drf = 1'b0, drdir = 1'b0, aoff = 1'b0, irf = 1'b0, orf = 1'b0;
  logic [63:0] pattern = 64'h0, out_img = 64'h0, field_in, latched;
  logic [63:0] in_image, field_out;
  logic [6:0]  op_mode, cur;
  logic [127:0] fen, fval;
  logic [63:0] ex;
  logic [1:0]  req_code;
  localparam logic [4:0] P_IRF  = 5'h01;
  localparam logic [4:0] P_ORF  = 5'h02;
  localparam logic [4:0] P_DRF  = 5'h04;
  localparam logic [4:0] P_KICK = 5'h08;
  localparam logic [4:0] P_SCAN = 5'h10;
  logic [31:0] seed = 32'h01FD0A5B;
  logic [1:0]  fixed [11] = '{2'h2, 2'h1, 2'h3, 2'h2, 2'h3, 2'h1, 2'h0,
                               2'h3, 2'h1, 2'h2, 2'h0};
  int          bad_count = 0, checks_done = 0, n;
  always #5 core_clk = ~core_clk;
  smfw_top #(.WDT_TICK_CYC(10), .BLINK_CYC(4)) uut (
    .core_clk(core_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .selector_pos(sel), .diag_fault(diag),
    .backup_invalid(bkinv), .scan_start(scan),
    .watchdog_kick_instruction(kick), .direct_refresh_instruction(drf),
    .direct_refresh_dir(drdir), .all_outputs_off_command(aoff),
    .input_refresh(irf), .output_refresh(orf), .field_in(field_in),
    .out_image(out_img), .in_image(in_image), .field_out(field_out),
    .program_enable(program_enable), .op_mode(op_mode),
    .fault_indicator(fault_ind), .running_indicator(run_ind));
  smfw_field_model field (.core_clk(core_clk), .pattern(pattern),
    .field_out(field_out), .field_in(field_in), .latched(latched));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [63:0] frc(logic [63:0] r, e, v, logic g);
    return g ? ((r & ~e) | (v & e)) : r;
  endfunction
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [6:0] nxt(logic [6:0] m, logic [1:0] r);
    case (m)
      7'h08: return r == 2'h1 ? 7'h10 : r == 2'h3 ? 7'h40 : m;
      7'h10: return r == 2'h2 ? 7'h20 : r == 2'h0 ? 7'h08 : m;
      7'h20: return r == 2'h1 ? 7'h10 : r == 2'h0 ? 7'h08 : m;
      7'h40: return r == 2'h0 ? 7'h08 : m;
      default: return m;
    endcase
  endfunction
  task automatic chk(input string nm, input logic [63:0] s, e);
    checks_done++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge core_clk);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    rdv = hrdata;
    chk("hresp", hresp, 1'b0);
  endtask
  task automatic rst(input int c);
    nrst <= 1'b0;
    repeat (c) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge core_clk);
  endtask
  task automatic pulse(input logic [4:0] m);
    @(posedge core_clk);
    {scan, kick, drf, orf, irf} <= m;
    @(posedge core_clk);
    {scan, kick, drf, orf, irf} <= 5'h00;
    repeat (2) @(posedge core_clk);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    summarize();
  end
  initial begin
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    // Retention clear must outlast the synchronisers once reset is gone
    repeat (4) @(posedge core_clk);
    bkinv <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk("op_mode rst", op_mode, 7'h01);
    bus(1'b0, smfw_pkg::OFS_WDT_LIM, 0);
    chk("wdt_lim rst", rdv, 32'h000000C8);
    bus(1'b0, 12'h0FC, 0);
    chk("unmapped", rdv, 32'h0);
    sel <= smfw_pkg::SEL_PAUREM;
    repeat (6) @(posedge core_clk);
    cur = 7'h08;
    chk("remote stop", op_mode, cur);
    for (int i = 0; i < 40; i++) begin
      seed = lfsr(seed);
      req_code = i < 11 ? fixed[i] : seed[1:0];
      bus(1'b1, smfw_pkg::OFS_MODE_REQ, {30'h0, req_code});
      cur = nxt(cur, req_code);
      repeat (2) @(posedge core_clk);
      chk("remote mode", op_mode, cur);
    end
    sel <= smfw_pkg::SEL_RUN;
    repeat (6) @(posedge core_clk);
    bus(1'b1, smfw_pkg::OFS_MODE_REQ, 32'h0);
    repeat (2) @(posedge core_clk);
    chk("local refuses", op_mode, 7'h02);
    bus(1'b0, smfw_pkg::OFS_STATUS, 0);
    chk("status", rdv, 32'h00000602);
    $display("mode test done");
    // Old settings are wiped first so no stale bit leaks into the new set
    bus(1'b1, smfw_pkg::OFS_CTRL, 32'h6);
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      fen[i*16 +: 16] = seed[15:0];
      fval[i*16 +: 16] = seed[31:16];
      bus(1'b1, {smfw_pkg::PAGE_FEN, 8'(4 * i)}, {16'h0, seed[15:0]});
      bus(1'b1, {smfw_pkg::PAGE_FVAL, 8'(4 * i)}, {16'h0, seed[31:16]});
    end
    bus(1'b1, {smfw_pkg::PAGE_FVAL, 8'hFC}, 32'h0000A5C3);
    bus(1'b0, {smfw_pkg::PAGE_FVAL, 8'hFC}, 0);
    chk("word 63", rdv, 32'h0000A5C3);
    bus(1'b0, {smfw_pkg::PAGE_FEN, 8'h0C}, 0);
    chk("enable word", rdv, {16'h0, fen[63:48]});
    pattern <= {seed, ~seed};
    out_img <= {~seed, seed};
    for (int g = 0; g < 2; g++) begin
      bus(1'b1, smfw_pkg::OFS_CTRL, 32'(g));
      pulse(P_IRF | P_ORF);
      ex = frc(pattern, fen[63:0], fval[63:0], g[0]);
      chk("in_image", in_image, ex);
      ex = frc(out_img, fen[127:64], fval[127:64], g[0]);
      chk("field_out", field_out, ex);
    end
    chk("field sees", latched, ex);
    seed = lfsr(seed);
    pattern <= {~seed, seed};
    out_img <= {seed, seed};
    repeat (4) @(posedge core_clk);
    pulse(P_DRF);
    ex = frc(pattern, fen[63:0], fval[63:0], 1'b1);
    chk("direct in", in_image, ex);
    drdir <= 1'b1;
    pulse(P_DRF);
    ex = frc(out_img, fen[127:64], fval[127:64], 1'b1);
    chk("direct out", field_out, ex);
    aoff <= 1'b1;
    pulse(P_ORF);
    chk("outputs off", field_out, 64'h0);
    aoff <= 1'b0;
    rst(3);
    bus(1'b0, smfw_pkg::OFS_CTRL, 0);
    chk("gfe kept", rdv[0], 1'b1);
    bus(1'b0, {smfw_pkg::PAGE_FVAL, 8'h04}, 0);
    chk("value kept", rdv, {16'h0, fval[31:16]});
    $display("force test done");
    bus(1'b1, smfw_pkg::OFS_WDT_LIM, 32'h2);
    // Kick at once: the count has been running since reset release
    pulse(P_ORF | P_KICK);
    for (int k = 0; k < 8; k++) begin
      repeat (12) @(posedge core_clk);
      pulse(k % 2 == 0 ? P_KICK : P_SCAN);
    end
    chk("kept running", run_ind, 1'b1);
    n = 0;
    while (run_ind === 1'b1 && n < 100) begin
      @(posedge core_clk);
      n++;
    end
    chk("wdt span", n >= 8 && n <= 26, 1'b1);
    chk("outputs dead", field_out, 64'h0);
    bus(1'b0, smfw_pkg::OFS_SYS_ERR, 0);
    chk("err code", rdv, 32'h00000011);
    bus(1'b0, smfw_pkg::OFS_STATUS, 0);
    chk("halt status", rdv, 32'h00000902);
    n = 0;
    for (int k = 0; k < 16; k++) begin
      @(posedge core_clk);
      n += fault_ind;
    end
    chk("blink", n >= 4 && n <= 12, 1'b1);
    chk("run off", run_ind, 1'b0);
    $display("watchdog test done");
    rst(3);
    diag <= 1'b1;
    repeat (6) @(posedge core_clk);
    bus(1'b0, smfw_pkg::OFS_SYS_ERR, 0);
    chk("diag code", rdv, 32'h00000012);
    chk("diag halt", program_enable, 1'b0);
    diag <= 1'b0;
    $display("diagnosis test done");
    summarize();
  end
endmodule
`default_nettype wire
